/* pkg/prwg_cfg.svh */
// Constants for the protected register write guard
`ifndef PRWG_CFG_SVH
`define PRWG_CFG_SVH
`define PRWG_A_WAIT_CTRL 28'hfff_f66e
`define PRWG_A_UNLOCK 28'hfff_f1fc
`define PRWG_A_SYS 28'hfff_f802
`define PRWG_A_G0 28'hfff_f1fe
`define PRWG_A_G1 28'hfff_f828
`define PRWG_A_G2 28'hfff_f82e
`define PRWG_A_G3 28'hfff_f888
`define PRWG_A_G4 28'hfff_f891
`define PRWG_A_G5 28'hfff_f892
`define PRWG_A_G6 28'hfff_f9fc
`define PRWG_WAIT_CTRL_RST 8'h77
`define PRWG_SYS_RST 8'h00
`define PRWG_ERR_BIT 0
`define PRWG_I_BIT 4
`define PRWG_J_BIT 0
`define PRWG_BASE_CLKS 5'h03
`define PRWG_K_BASE 5'h02
`define PRWG_K_RD 3'h1
`define PRWG_K_CMP 3'h3
`define PRWG_K_WDT 3'h3
`endif

/* pkg/prwg_pkg.sv */
// Types for the protected register write guard
package prwg_pkg;
  typedef enum logic [1:0]
  {
    PRWG_CLS_PLAIN = 2'h0,
    PRWG_CLS_RESULT_RD = 2'h1,
    PRWG_CLS_CMP_WR = 2'h2,
    PRWG_CLS_WDT_WR = 2'h3
  } prwg_cls_t;

  typedef enum logic [2:0]
  {
    PRWG_ST_IDLE = 3'h1,
    PRWG_ST_WAIT = 3'h2,
    PRWG_ST_HANG = 3'h4
  } prwg_state_t;

  typedef struct packed
  {
    logic [27:0] addr;
    logic we;
    logic bitop;
    logic [7:0] wdata;
    prwg_cls_t cls;
    logic phase;
  } prwg_req_t;
endpackage

/* hw/prwg_decode.sv */
// Address decode of guarded, unlock, status and wait registers
`include "prwg_cfg.svh"
module prwg_decode (
  input wire logic [27:0] addr,
  output logic [6:0] hit,
  output logic is_unlock,
  output logic is_sys,
  output logic is_wait
);
  localparam logic [6:0][27:0] GUARD_ADDR = {`PRWG_A_G6, `PRWG_A_G5, `PRWG_A_G4, `PRWG_A_G3,
                                             `PRWG_A_G2, `PRWG_A_G1, `PRWG_A_G0};

  genvar g;
  generate
    for (g = 0; g < 7; g++)
    begin : gen_hit
      assign hit[g] = (addr == GUARD_ADDR[g]);
    end
  endgenerate

  assign is_unlock = (addr == `PRWG_A_UNLOCK);
  assign is_sys = (addr == `PRWG_A_SYS);
  assign is_wait = (addr == `PRWG_A_WAIT_CTRL);
endmodule

/* hw/prwg_wait_calc.sv */
// Peripheral access length from wait settings and sync factor
`include "prwg_cfg.svh"
module prwg_wait_calc (
  input wire logic i_sel,
  input wire logic j_sel,
  input wire logic [2:0] k,
  output logic [4:0] clks
);
  logic [9:0] prod;

  assign prod = {5'h00, `PRWG_K_BASE + {4'h0, j_sel}} * {7'h00, k};
  // Three clocks base, plus set waits, plus synchronisation stretch
  assign clks = `PRWG_BASE_CLKS + {4'h0, i_sel} + {4'h0, j_sel} + prod[4:0];
endmodule

/* hw/prwg_guard.sv */
// Protected register write guard with peripheral access timing
`include "prwg_cfg.svh"
module prwg_guard (
  input wire logic clock,
  input wire logic rst,
  input wire logic req_valid,
  input wire prwg_pkg::prwg_req_t req,
  input wire logic [7:0] periph_rdata,
  input wire logic wdt_running,
  input wire logic osc_unsafe,
  input wire logic opt_read_bad,
  output logic ack_q,
  output logic [7:0] rdata_q,
  output logic stall_q,
  output logic irq_hold_q,
  output logic [6:0] guard_we_q,
  output logic [7:0] guard_wdata_q,
  output logic [7:0] wait_ctrl_q,
  output logic prot_err_q
);
  // ----------------------------------------
  // Decode and timing
  // ----------------------------------------
  logic take;
  logic hang_go;
  logic [6:0] hit;
  logic is_unlock;
  logic is_sys;
  logic is_wait;
  logic [2:0] k;
  logic [4:0] clks;
  prwg_pkg::prwg_state_t st_q;
  prwg_pkg::prwg_state_t st_d;

  assign take = req_valid && (st_q == prwg_pkg::PRWG_ST_IDLE);
  // Sync access while on a slow or internal clock never completes
  assign hang_go = osc_unsafe && (req.cls != prwg_pkg::PRWG_CLS_PLAIN);

  prwg_decode u_decode (
    .addr(req.addr),
    .hit(hit),
    .is_unlock(is_unlock),
    .is_sys(is_sys),
    .is_wait(is_wait)
  );

  prwg_wait_calc u_wait (
    .i_sel(wait_ctrl_q[`PRWG_I_BIT]),
    .j_sel(wait_ctrl_q[`PRWG_J_BIT]),
    .k(k),
    .clks(clks)
  );

  logic cmp_last_q;
  logic cmp_last_d;

  always_comb
  begin
    k = 3'h0;
    case (req.cls)
      prwg_pkg::PRWG_CLS_RESULT_RD:
      begin
        if (!req.we)
          k = `PRWG_K_RD + {2'h0, req.phase};
      end
      prwg_pkg::PRWG_CLS_CMP_WR:
      begin
        if (!req.we)
          k = `PRWG_K_RD + {2'h0, req.phase};
        else if (cmp_last_q)
          k = `PRWG_K_CMP + {2'h0, req.phase};
      end
      prwg_pkg::PRWG_CLS_WDT_WR:
      begin
        if (req.we && wdt_running)
          k = `PRWG_K_WDT;
      end
      default:
      begin
        k = 3'h0;
      end
    endcase
  end

  // ----------------------------------------
  // Protection state
  // ----------------------------------------
  logic arm_q;
  logic arm_d;
  logic irq_hold_d;
  logic [6:0] guard_we_d;
  logic [7:0] guard_wdata_d;
  logic [7:0] wait_ctrl_d;
  logic prot_err_d;
  logic set_ev;
  logic clr_ev;
  logic clr_pri;

  always_comb
  begin
    arm_d = arm_q;
    irq_hold_d = irq_hold_q;
    guard_we_d = 7'h00;
    guard_wdata_d = guard_wdata_q;
    wait_ctrl_d = wait_ctrl_q;
    cmp_last_d = cmp_last_q;
    set_ev = opt_read_bad;
    clr_ev = 1'b0;
    clr_pri = 1'b0;
    if (take)
    begin
      cmp_last_d = req.we && (req.cls == prwg_pkg::PRWG_CLS_CMP_WR);
      // Reads leave the permission and the flag alone
      if (req.we)
      begin
        if (is_unlock)
        begin
          set_ev = set_ev | arm_q;
          arm_d = 1'b1;
          irq_hold_d = 1'b1;
        end
        else
        begin
          arm_d = 1'b0;
          irq_hold_d = 1'b0;
          if (|hit)
          begin
            if (arm_q)
            begin
              guard_we_d = hit;
              guard_wdata_d = req.wdata;
            end
            else
            begin
              set_ev = 1'b1;
            end
          end
          else if (arm_q)
          begin
            set_ev = 1'b1;
          end
          if (is_wait)
            wait_ctrl_d = req.wdata;
          if (is_sys && !req.wdata[`PRWG_ERR_BIT])
          begin
            clr_ev = 1'b1;
            clr_pri = arm_q;
          end
        end
      end
    end
    // Set beats clear, except a clear right after unlock, which only opt_read_bad beats
    if (clr_pri)
      prot_err_d = opt_read_bad;
    else
      prot_err_d = set_ev | (prot_err_q & ~clr_ev);
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      arm_q <= 1'b0;
      irq_hold_q <= 1'b0;
      guard_we_q <= 7'h00;
      guard_wdata_q <= 8'h00;
      wait_ctrl_q <= `PRWG_WAIT_CTRL_RST;
      cmp_last_q <= 1'b0;
      prot_err_q <= 1'(`PRWG_SYS_RST >> `PRWG_ERR_BIT);
    end
    else
    begin
      arm_q <= arm_d;
      irq_hold_q <= irq_hold_d;
      guard_we_q <= guard_we_d;
      guard_wdata_q <= guard_wdata_d;
      wait_ctrl_q <= wait_ctrl_d;
      cmp_last_q <= cmp_last_d;
      prot_err_q <= prot_err_d;
    end
  end

  // ----------------------------------------
  // Access sequencer
  // ----------------------------------------
  logic [4:0] cnt_q;
  logic [4:0] cnt_d;
  logic [1:0] rsel_q;
  logic [1:0] rsel_d;
  logic ack_d;
  logic stall_d;
  logic [7:0] rdata_d;

  always_comb
  begin
    st_d = st_q;
    cnt_d = cnt_q;
    rsel_d = rsel_q;
    ack_d = 1'b0;
    stall_d = stall_q;
    rdata_d = rdata_q;
    case (st_q)
      prwg_pkg::PRWG_ST_IDLE:
      begin
        if (take)
        begin
          stall_d = 1'b1;
          cnt_d = clks - 5'h02;
          st_d = hang_go ? prwg_pkg::PRWG_ST_HANG : prwg_pkg::PRWG_ST_WAIT;
          if (is_wait)
            rsel_d = 2'h1;
          else if (is_sys)
            rsel_d = 2'h2;
          else if (is_unlock)
            rsel_d = 2'h3;
          else
            rsel_d = 2'h0;
        end
      end
      prwg_pkg::PRWG_ST_WAIT:
      begin
        if (cnt_q == 5'h00)
        begin
          st_d = prwg_pkg::PRWG_ST_IDLE;
          ack_d = 1'b1;
          stall_d = 1'b0;
          case (rsel_q)
            2'h1: rdata_d = wait_ctrl_q;
            2'h2: rdata_d = {7'h00, prot_err_q};
            2'h3: rdata_d = 8'h00;
            default: rdata_d = periph_rdata;
          endcase
        end
        else
        begin
          cnt_d = cnt_q - 5'h01;
        end
      end
      prwg_pkg::PRWG_ST_HANG:
      begin
        stall_d = 1'b1;
      end
      default:
      begin
        st_d = prwg_pkg::PRWG_ST_IDLE;
        stall_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      st_q <= prwg_pkg::PRWG_ST_IDLE;
      cnt_q <= 5'h00;
      rsel_q <= 2'h0;
      ack_q <= 1'b0;
      stall_q <= 1'b0;
      rdata_q <= 8'h00;
    end
    else
    begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      rsel_q <= rsel_d;
      ack_q <= ack_d;
      stall_q <= stall_d;
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic [4:0] span_q;
  logic [4:0] exp_q;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      span_q <= 5'h00;
      exp_q <= 5'h00;
    end
    else if (take)
    begin
      span_q <= 5'h01;
      exp_q <= clks;
    end
    else if (stall_q)
    begin
      span_q <= span_q + 5'h01;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  sequence s_guard_take;
    take && req.we && (|hit);
  endsequence

  sequence s_plain_take;
    take && !hang_go && (k == 3'h0) && (wait_ctrl_q == 8'h00);
  endsequence

  AST_GUARD_ARMED: assert property (s_guard_take and arm_q |=> guard_we_q == $past(hit))
    else $error("armed guarded write not passed");
  AST_GUARD_BLOCKED: assert property (s_guard_take and !arm_q |=> guard_we_q == 7'h00 && prot_err_q)
    else $error("unarmed guarded write not blocked");
  AST_UNLOCK_TWICE: assert property (take && req.we && is_unlock && arm_q |=> prot_err_q && irq_hold_q)
    else $error("double unlock missed");
  AST_OTHER_AFTER_ARM: assert property (take && req.we && !is_unlock && !(|hit) && !is_sys && arm_q
    |=> prot_err_q && !arm_q)
    else $error("stray write after unlock missed");
  AST_ERR_STICKY: assert property (prot_err_q && !(take && req.we && is_sys) |=> prot_err_q)
    else $error("error flag dropped");
  AST_CLEAR_WINS: assert property (take && req.we && is_sys && !req.wdata[`PRWG_ERR_BIT] && arm_q
    && !opt_read_bad |=> !prot_err_q)
    else $error("clear after unlock lost");
  AST_READ_KEEPS_ARM: assert property (take && !req.we && arm_q && !opt_read_bad
    |=> arm_q && $stable(prot_err_q))
    else $error("read disturbed permission");
  AST_OPT_ERR: assert property (opt_read_bad |=> prot_err_q)
    else $error("option read error missed");
  AST_BASE_ACCESS: assert property (s_plain_take |=> stall_q [*2] ##1 (ack_q && !stall_q))
    else $error("plain access not three clocks");
  AST_WAIT_LEN: assert property (ack_q |-> span_q == exp_q)
    else $error("access length wrong");
  AST_HANG: assert property (take && hang_go |=> (stall_q && !ack_q) [*8])
    else $error("prohibited access released");
endmodule

/* verif/prwg_cpu.sv */
// CPU core model issuing peripheral register accesses
module prwg_cpu (
  input wire logic clock,
  input wire logic ack_q,
  input wire logic stall_q,
  input wire logic [7:0] rdata_q,
  output logic req_valid,
  output prwg_pkg::prwg_req_t req
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    req_valid = 1'b0;
    req = '0;
  end

  // One byte access; n is 0 when no ack came within the bound
  task automatic access(input logic [27:0] a, input logic w, input logic [7:0] d,
    input prwg_pkg::prwg_cls_t c, input logic ph, output logic [7:0] rd, output int n, output int s);
    @(posedge clock);
    req_valid <= 1'b1;
    req <= '{addr: a, we: w, bitop: 1'b0, wdata: d, cls: c, phase: ph};
    @(posedge clock);
    req_valid <= 1'b0;
    n = 0;
    s = 0;
    rd = 8'h00;
    // Each pass looks just after an edge at what the next edge samples
    while (n < 40)
    begin
      #1;
      n++;
      if (ack_q === 1'b1)
        break;
      if (stall_q === 1'b1)
        s++;
      @(posedge clock);
    end
    // Stalled until the access completed; the CPU issues nothing meanwhile
    if (ack_q !== 1'b1)
      n = 0;
    rd = rdata_q;
  endtask
endmodule

/* verif/prwg_guard_tb.sv */
// Self-checking testbench of the protected register write guard
`include "prwg_cfg.svh"
module prwg_guard_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic clock, rst, req_valid, wdt_running, osc_unsafe, opt_read_bad;
  prwg_pkg::prwg_req_t req;
  logic [7:0] periph_rdata, rdata_q, guard_wdata_q, wait_ctrl_q, rd_g, d, wd_seen;
  logic ack_q, stall_q, irq_hold_q, prot_err_q, hang_ok;
  logic [6:0] guard_we_q, we_seen;
  logic [27:0] ga [7];
  int errors, comparisons, n_g, s_g, rs;
  logic i, j;

  // ------------------------------
  // Instances and clock
  // ------------------------------
  prwg_guard dut_u (.clock(clock), .rst(rst), .req_valid(req_valid), .req(req), .periph_rdata(periph_rdata),
    .wdt_running(wdt_running), .osc_unsafe(osc_unsafe), .opt_read_bad(opt_read_bad), .ack_q(ack_q),
    .rdata_q(rdata_q), .stall_q(stall_q), .irq_hold_q(irq_hold_q), .guard_we_q(guard_we_q),
    .guard_wdata_q(guard_wdata_q), .wait_ctrl_q(wait_ctrl_q), .prot_err_q(prot_err_q));
  prwg_cpu cpu_u (.clock(clock), .ack_q(ack_q), .stall_q(stall_q), .rdata_q(rdata_q), .req_valid(req_valid),
    .req(req));

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Remember the last guarded write strobe
  always @(posedge clock)
    if (guard_we_q !== 7'h00)
    begin
      we_seen <= guard_we_q;
      wd_seen <= guard_wdata_q;
    end

  // ------------------------------
  // Helpers
  // ------------------------------
  function automatic int clks(input logic ii, input logic jj, input int k);
    return 3 + ii + jj + (2 + jj) * k;
  endfunction

  task automatic tally_and_finish;
    $display("comparisons=%0d errors=%0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chkn(input int got, input int exp);
    comparisons++;
    if (got != exp)
    begin
      errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic acc(input logic [27:0] a, input logic w, input logic [7:0] dd, input prwg_pkg::prwg_cls_t c,
    input logic ph);
    cpu_u.access(a, w, dd, c, ph, rd_g, n_g, s_g);
    if (n_g == 0 && !hang_ok)
    begin
      errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, 0, 1);
      tally_and_finish;
    end
  endtask

  task automatic wr(input logic [27:0] a, input logic [7:0] dd);
    acc(a, 1'b1, dd, prwg_pkg::PRWG_CLS_PLAIN, 1'b0);
  endtask

  task automatic rd(input logic [27:0] a);
    acc(a, 1'b0, 8'h00, prwg_pkg::PRWG_CLS_PLAIN, 1'b0);
  endtask

  // ------------------------------
  // Main sequence
  // ------------------------------
  initial
  begin
    ga = '{`PRWG_A_G0, `PRWG_A_G1, `PRWG_A_G2, `PRWG_A_G3, `PRWG_A_G4, `PRWG_A_G5, `PRWG_A_G6};
    rst = 1'b1;
    periph_rdata = 8'h00;
    wdt_running = 1'b0;
    osc_unsafe = 1'b0;
    opt_read_bad = 1'b0;
    hang_ok = 1'b0;
    we_seen = 7'h00;
    errors = 0;
    comparisons = 0;
    rs = $urandom(93);
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    #1;
    chk(wait_ctrl_q, `PRWG_WAIT_CTRL_RST);
    rd(`PRWG_A_SYS);
    chk(rd_g, `PRWG_SYS_RST);
    chkn(n_g, 5);
    $display("test reset done");
    for (int v = 0; v < 4; v++)
    begin
      i = v[1];
      j = v[0];
      wr(`PRWG_A_WAIT_CTRL, {3'h0, i, 3'h0, j});
      rd(`PRWG_A_WAIT_CTRL);
      chk(rd_g, {3'h0, i, 3'h0, j});
      chkn(n_g, clks(i, j, 0));
      chkn(s_g, n_g - 1);
      for (int ph = 0; ph < 2; ph++)
      begin
        @(posedge clock);
        periph_rdata <= 8'($urandom);
        acc(28'h000_0100, 1'b0, 8'h00, prwg_pkg::PRWG_CLS_RESULT_RD, ph[0]);
        chk(rd_g, periph_rdata);
        chkn(n_g, clks(i, j, 1 + ph));
        acc(28'h000_0102, 1'b1, 8'($urandom), prwg_pkg::PRWG_CLS_CMP_WR, ph[0]);
        chkn(n_g, clks(i, j, 0));
        acc(28'h000_0102, 1'b1, 8'($urandom), prwg_pkg::PRWG_CLS_CMP_WR, ph[0]);
        chkn(n_g, clks(i, j, 3 + ph));
        @(posedge clock);
        wdt_running <= ph[0];
        acc(28'h000_0104, 1'b1, 8'($urandom), prwg_pkg::PRWG_CLS_WDT_WR, 1'b0);
        chkn(n_g, clks(i, j, 3 * ph));
      end
    end
    chk({7'h00, prot_err_q}, 8'h00);
    $display("test timing done");
    for (int g = 0; g < 7; g++)
    begin
      d = 8'($urandom);
      we_seen = 7'h00;
      wr(`PRWG_A_UNLOCK, d);
      chk({7'h00, irq_hold_q}, 8'h01);
      if (g % 2 == 1)
      begin
        rd(ga[g]);
        chk(rd_g, periph_rdata);
      end
      wr(ga[g], d);
      chk({1'b0, we_seen}, 8'h01 << g);
      chk(wd_seen, d);
      chk({7'h00, irq_hold_q, prot_err_q}, 8'h00);
    end
    we_seen = 7'h00;
    wr(ga[0], 8'h5a);
    chk({1'b0, we_seen}, 8'h00);
    rd(`PRWG_A_SYS);
    chk(rd_g, 8'h01);
    wr(`PRWG_A_SYS, 8'h01);
    chk({7'h00, prot_err_q}, 8'h01);
    wr(`PRWG_A_SYS, 8'h00);
    chk({7'h00, prot_err_q}, 8'h00);
    $display("test guarded done");
    wr(`PRWG_A_UNLOCK, 8'h33);
    wr(`PRWG_A_WAIT_CTRL, 8'h11);
    chk({7'h00, prot_err_q}, 8'h01);
    we_seen = 7'h00;
    wr(ga[2], 8'h44);
    chk({1'b0, we_seen}, 8'h00);
    wr(`PRWG_A_SYS, 8'h00);
    wr(`PRWG_A_UNLOCK, 8'h01);
    wr(`PRWG_A_UNLOCK, 8'h02);
    chk({7'h00, prot_err_q}, 8'h01);
    wr(`PRWG_A_SYS, 8'h00);
    chk({7'h00, prot_err_q}, 8'h00);
    wr(`PRWG_A_UNLOCK, 8'h77);
    rd(`PRWG_A_UNLOCK);
    chk(rd_g, 8'h00);
    we_seen = 7'h00;
    wr(ga[0], 8'h77);
    chk({1'b0, we_seen}, 8'h01);
    // Idle cycles after the last guarded write before further work
    repeat (5) @(posedge clock);
    @(posedge clock);
    opt_read_bad <= 1'b1;
    @(posedge clock);
    opt_read_bad <= 1'b0;
    @(posedge clock);
    #1;
    chk({7'h00, prot_err_q}, 8'h01);
    $display("test error flag done");
    @(posedge clock);
    osc_unsafe <= 1'b1;
    hang_ok = 1'b1;
    acc(28'h000_0100, 1'b0, 8'h00, prwg_pkg::PRWG_CLS_RESULT_RD, 1'b0);
    chkn(n_g, 0);
    chk({7'h00, stall_q}, 8'h01);
    hang_ok = 1'b0;
    @(posedge clock);
    rst <= 1'b1;
    osc_unsafe <= 1'b0;
    @(posedge clock);
    rst <= 1'b0;
    #1;
    chk({stall_q, prot_err_q, 6'h00}, 8'h00);
    chk(wait_ctrl_q, 8'h77);
    $display("test hang done");
    tally_and_finish;
  end
endmodule
